// [shared/bcu_params.svh]
`ifndef BCU_PARAMS_SVH
`define BCU_PARAMS_SVH

// Register byte offsets
`define BCU_OFF_INSTR     6'h00
`define BCU_OFF_PC        6'h04
`define BCU_OFF_OPERAND   6'h08
`define BCU_OFF_INDEX     6'h0c
`define BCU_OFF_BASE      6'h10
`define BCU_OFF_INDIRECT  6'h14
`define BCU_OFF_CTRL      6'h18
`define BCU_OFF_STATUS    6'h1c
`define BCU_OFF_NEXT_PC   6'h20
`define BCU_OFF_RESULT    6'h24
`define BCU_OFF_EA        6'h28

// Opcodes
`define BCU_OPC_EXC_TEST  8'h9d
`define BCU_OPC_XEQ_TEST  8'h9c
`define BCU_OPC_IDT_HI    5'h11

// Instruction field positions
`define BCU_OPC_MSB       31
`define BCU_OPC_LSB       24
`define BCU_R_MSB         23
`define BCU_R_LSB         20
`define BCU_T_MSB         19
`define BCU_T_LSB         16
`define BCU_M_MSB         15
`define BCU_M_LSB         12
`define BCU_N_MSB         11
`define BCU_IDT_XV_BIT    2
`define BCU_IDT_DEC_BIT   1
`define BCU_IDT_NZ_BIT    0

// Status field positions
`define BCU_ST_EXC_LSB    0
`define BCU_ST_IND_LSB    4
`define BCU_ST_RC_LSB     8
`define BCU_ST_TAKEN_BIT  12

// Reset values
`define BCU_RST_WORD      32'h0000_0000
`define BCU_RST_FLAGS     4'h0
`define BCU_RST_RC        3'h0

// Result code encodings
`define BCU_RC_NEG        3'h4
`define BCU_RC_POS        3'h2
`define BCU_RC_ZERO       3'h1

`endif

// [shared/bcu_pkg.sv]
package bcu_pkg;

  typedef enum logic [1:0] {
    BCU_OP_NONE = 2'b00,
    BCU_OP_EXC  = 2'b01,
    BCU_OP_XEQ  = 2'b10,
    BCU_OP_IDT  = 2'b11
  } bcu_op_t;

  typedef enum logic [1:0] {
    BCU_WB_NONE   = 2'b00,
    BCU_WB_ACC    = 2'b01,
    BCU_WB_INDEX  = 2'b10,
    BCU_WB_VECTOR = 2'b11
  } bcu_wb_t;

endpackage : bcu_pkg

// [verilog/bcu_branch_condition_unit.sv]
`timescale 1ns/100ps
`include "bcu_params.svh"
// Behaviour
// - Exception branch when selected flag is set
// - R bits map divide, fixed, expover, expunder
// - Exception flags accumulate until tested
// - Exception branch clears only selected flags
// - Exception branch target like compare branch
// - Target from T, M, N fields
// - Compare code and result code untouched
// - Indicator branch when selected indicator set
// - Executed met condition sets satisfied flag
// - Executed monitor call sets monitor flag
// - Executed branch or monitor call suppressed
// - R codes select satisfied, monitor, both
// - Indicator branch clears only selected bits
// - Four-bit indicator, upper two held zero
// - 88 increments accumulator, branch on zero
// - 8C increments index or vector, zero
// - 89 and 8D increment, branch nonzero
// - 8A and 8E decrement, branch zero
// - 8B and 8F decrement, branch nonzero
// - Result code from sign of new value
module bcu_branch_condition_unit
  import bcu_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [5:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic [3:0]  exc_set_in,
  input  wire logic        xeq_cond_met_in,
  input  wire logic        xeq_monitor_in,
  output logic      [31:0] next_pc_out,
  output logic             branch_taken_out,
  output logic             exec_done_out,
  output logic             wb_valid_out,
  output bcu_wb_t          wb_target_out,
  output logic      [3:0]  wb_index_out,
  output logic      [31:0] wb_value_out,
  output logic      [2:0]  result_code_out,
  output logic      [3:0]  exc_flags_out,
  output logic      [3:0]  indicator_out,
  output logic             monitor_suppress_out
);

  function automatic logic reg_hit(input logic [5:0] addr, input logic [5:0] off);
    reg_hit = (addr[5:2] == off[5:2]);
  endfunction : reg_hit

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    be_merge = res;
  endfunction : be_merge

  function automatic logic [2:0] sign_code(input logic [31:0] v);
    if (v == 32'h0000_0000) begin
      sign_code = `BCU_RC_ZERO;
    end else if (v[31]) begin
      sign_code = `BCU_RC_NEG;
    end else begin
      sign_code = `BCU_RC_POS;
    end
  endfunction : sign_code

  function automatic logic mask_hit(input logic [3:0] sel, input logic [3:0] flags);
    mask_hit = |(sel & flags);
  endfunction : mask_hit

  logic [31:0] pc_r;
  logic [31:0] operand_r;
  logic [31:0] index_r;
  logic [31:0] base_r;
  logic [31:0] indirect_r;
  logic        xeq_mode_r;
  logic [31:0] ea_r;
  logic [31:0] result_r;
  logic        bus_req;
  logic        bus_acc;
  logic        exec;
  logic [7:0]  opc;
  logic [3:0]  rf;
  logic [3:0]  tf;
  logic [3:0]  mf;
  logic [11:0] nf;
  bcu_op_t     op;
  logic [31:0] base_part;
  logic [31:0] ea;
  logic [31:0] target;
  logic [31:0] idt_new;
  logic        idt_zero;
  logic        cond;
  logic        taken;
  logic [31:0] seq_pc;
  logic [31:0] pc_nxt;
  logic [3:0]  exc_clr;
  logic [1:0]  ind_clr;
  logic        cond_set;
  logic        mon_set;
  logic [31:0] status;
  logic [31:0] rd_nxt;

  // Bus handshake: one wait cycle, then the access completes
  assign bus_req = avs_read_in | avs_write_in;
  assign bus_acc = bus_req & ~avs_waitrequest_out;
  assign exec    = bus_acc & avs_write_in & reg_hit(avs_address_in, `BCU_OFF_INSTR);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
    end
  end

  // Instruction fields
  assign opc = avs_writedata_in[`BCU_OPC_MSB:`BCU_OPC_LSB];
  assign rf  = avs_writedata_in[`BCU_R_MSB:`BCU_R_LSB];
  assign tf  = avs_writedata_in[`BCU_T_MSB:`BCU_T_LSB];
  assign mf  = avs_writedata_in[`BCU_M_MSB:`BCU_M_LSB];
  assign nf  = avs_writedata_in[`BCU_N_MSB:0];

  always_comb begin
    if (opc == `BCU_OPC_EXC_TEST) begin
      op = BCU_OP_EXC;
    end else if (opc == `BCU_OPC_XEQ_TEST) begin
      op = BCU_OP_XEQ;
    end else if (opc[7:3] == `BCU_OPC_IDT_HI) begin
      op = BCU_OP_IDT;
    end else begin
      op = BCU_OP_NONE;
    end
  end

  // Branch target
  always_comb begin
    if (mf == 4'h0) begin
      base_part = pc_r + {{20{nf[11]}}, nf};
    end else begin
      base_part = base_r + {20'h0_0000, nf};
    end
    if (tf[2:0] != 3'h0) begin
      ea = base_part + index_r;
    end else begin
      ea = base_part;
    end
    target = tf[3] ? indirect_r : ea;
  end

  // Modify and test
  assign idt_new  = opc[`BCU_IDT_DEC_BIT] ? operand_r - 32'h0000_0001
                                          : operand_r + 32'h0000_0001;
  assign idt_zero = (idt_new == 32'h0000_0000);

  always_comb begin
    case (op)
      BCU_OP_EXC: cond = mask_hit(rf, exc_flags_out);
      BCU_OP_XEQ: cond = mask_hit(rf, indicator_out);
      BCU_OP_IDT: cond = opc[`BCU_IDT_NZ_BIT] ? ~idt_zero : idt_zero;
      default:    cond = 1'b0;
    endcase
  end

  assign taken  = cond & ~xeq_mode_r;
  assign seq_pc = pc_r + 32'h0000_0001;
  assign pc_nxt = taken ? target : seq_pc;

  // Program counter and next address
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pc_r             <= `BCU_RST_WORD;
      next_pc_out      <= `BCU_RST_WORD;
      branch_taken_out <= 1'b0;
      ea_r             <= `BCU_RST_WORD;
    end else if (exec) begin
      pc_r             <= pc_nxt;
      next_pc_out      <= pc_nxt;
      branch_taken_out <= taken;
      ea_r             <= ea;
    end else if (bus_acc & avs_write_in & reg_hit(avs_address_in, `BCU_OFF_PC)) begin
      pc_r <= be_merge(pc_r, avs_writedata_in, avs_byteenable_in);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      exec_done_out <= 1'b0;
    end else begin
      exec_done_out <= exec;
    end
  end

  // Operand and addressing registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      operand_r  <= `BCU_RST_WORD;
      index_r    <= `BCU_RST_WORD;
      base_r     <= `BCU_RST_WORD;
      indirect_r <= `BCU_RST_WORD;
      xeq_mode_r <= 1'b0;
    end else if (bus_acc & avs_write_in) begin
      if (reg_hit(avs_address_in, `BCU_OFF_OPERAND)) begin
        operand_r <= be_merge(operand_r, avs_writedata_in, avs_byteenable_in);
      end
      if (reg_hit(avs_address_in, `BCU_OFF_INDEX)) begin
        index_r <= be_merge(index_r, avs_writedata_in, avs_byteenable_in);
      end
      if (reg_hit(avs_address_in, `BCU_OFF_BASE)) begin
        base_r <= be_merge(base_r, avs_writedata_in, avs_byteenable_in);
      end
      if (reg_hit(avs_address_in, `BCU_OFF_INDIRECT)) begin
        indirect_r <= be_merge(indirect_r, avs_writedata_in, avs_byteenable_in);
      end
      if (reg_hit(avs_address_in, `BCU_OFF_CTRL) & avs_byteenable_in[0]) begin
        xeq_mode_r <= avs_writedata_in[0];
      end
    end
  end

  // Write back of the modified register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wb_valid_out  <= 1'b0;
      wb_target_out <= BCU_WB_NONE;
      wb_index_out  <= 4'h0;
      wb_value_out  <= `BCU_RST_WORD;
      result_r      <= `BCU_RST_WORD;
    end else begin
      wb_valid_out <= exec & (op == BCU_OP_IDT);
      if (exec & (op == BCU_OP_IDT)) begin
        if (!opc[`BCU_IDT_XV_BIT]) begin
          wb_target_out <= BCU_WB_ACC;
        end else if (rf[3]) begin
          wb_target_out <= BCU_WB_VECTOR;
        end else begin
          wb_target_out <= BCU_WB_INDEX;
        end
        wb_index_out <= rf;
        wb_value_out <= idt_new;
        result_r     <= idt_new;
      end
    end
  end

  // Result code: only the modify-and-test group touches it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_code_out <= `BCU_RST_RC;
    end else if (exec & (op == BCU_OP_IDT)) begin
      result_code_out <= sign_code(idt_new);
    end
  end

  // Exception flags: new events win over the test clear
  assign exc_clr = (exec & (op == BCU_OP_EXC)) ? rf : 4'h0;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      exc_flags_out <= `BCU_RST_FLAGS;
    end else begin
      exc_flags_out <= (exc_flags_out & ~exc_clr) | exc_set_in;
    end
  end

  // Execute indicators
  assign ind_clr  = (exec & (op == BCU_OP_XEQ)) ? rf[1:0] : 2'h0;
  assign cond_set = xeq_cond_met_in | (exec & xeq_mode_r & cond);
  assign mon_set  = xeq_monitor_in;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      indicator_out <= `BCU_RST_FLAGS;
    end else begin
      indicator_out <= {2'b00,
                        (indicator_out[1:0] & ~ind_clr) | {mon_set, cond_set}};
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      monitor_suppress_out <= 1'b0;
    end else begin
      monitor_suppress_out <= xeq_monitor_in;
    end
  end

  // Read back
  always_comb begin
    status = 32'h0000_0000;
    status[`BCU_ST_EXC_LSB +: 4] = exc_flags_out;
    status[`BCU_ST_IND_LSB +: 4] = indicator_out;
    status[`BCU_ST_RC_LSB +: 3]  = result_code_out;
    status[`BCU_ST_TAKEN_BIT]    = branch_taken_out;
    rd_nxt = 32'h0000_0000;
    if (reg_hit(avs_address_in, `BCU_OFF_PC)) begin
      rd_nxt = pc_r;
    end else if (reg_hit(avs_address_in, `BCU_OFF_OPERAND)) begin
      rd_nxt = operand_r;
    end else if (reg_hit(avs_address_in, `BCU_OFF_INDEX)) begin
      rd_nxt = index_r;
    end else if (reg_hit(avs_address_in, `BCU_OFF_BASE)) begin
      rd_nxt = base_r;
    end else if (reg_hit(avs_address_in, `BCU_OFF_INDIRECT)) begin
      rd_nxt = indirect_r;
    end else if (reg_hit(avs_address_in, `BCU_OFF_CTRL)) begin
      rd_nxt = {31'h0, xeq_mode_r};
    end else if (reg_hit(avs_address_in, `BCU_OFF_STATUS)) begin
      rd_nxt = status;
    end else if (reg_hit(avs_address_in, `BCU_OFF_NEXT_PC)) begin
      rd_nxt = next_pc_out;
    end else if (reg_hit(avs_address_in, `BCU_OFF_RESULT)) begin
      rd_nxt = result_r;
    end else if (reg_hit(avs_address_in, `BCU_OFF_EA)) begin
      rd_nxt = ea_r;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out <= `BCU_RST_WORD;
    end else if (bus_req & avs_read_in & avs_waitrequest_out) begin
      avs_readdata_out <= rd_nxt;
    end
  end

  // Checks
  a_wait_one_cycle: assert property (@(posedge clk_in) disable iff (rst_in)
    (bus_req & avs_waitrequest_out) |=> !avs_waitrequest_out)
    else $error("waitrequest not released after one cycle");

  a_exc_flag_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
    (exc_set_in != 4'h0) |=> ((exc_flags_out & $past(exc_set_in)) == $past(exc_set_in)))
    else $error("exception event lost");

  a_exc_sel_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (exec && op == BCU_OP_EXC && exc_set_in == 4'h0) |=>
      (exc_flags_out == ($past(exc_flags_out) & ~$past(rf))))
    else $error("exception clear touched wrong flags");

  a_exc_branch_dec: assert property (@(posedge clk_in) disable iff (rst_in)
    (exec && op == BCU_OP_EXC && !xeq_mode_r) |=>
      (branch_taken_out == ($past(rf & exc_flags_out) != 4'h0)))
    else $error("exception branch decision wrong");

  a_ind_spare_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    indicator_out[3:2] == 2'b00)
    else $error("spare indicator bits not zero");

  a_ind_sel_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (exec && op == BCU_OP_XEQ && !xeq_cond_met_in && !xeq_monitor_in) |=>
      (indicator_out[1:0] == (($past(indicator_out[1:0]) & ~$past(rf[1:0]))
                              | {1'b0, $past(xeq_mode_r & cond)})))
    else $error("indicator clear touched wrong bits");

  a_rc_unchanged: assert property (@(posedge clk_in) disable iff (rst_in)
    (exec && op != BCU_OP_IDT) |=> $stable(result_code_out))
    else $error("result code changed by branch test");

  a_rc_sign_code: assert property (@(posedge clk_in) disable iff (rst_in)
    (exec && op == BCU_OP_IDT) |=> (result_code_out == sign_code(wb_value_out)))
    else $error("result code does not match new value");

  a_idt_next_pc: assert property (@(posedge clk_in) disable iff (rst_in)
    (exec && op == BCU_OP_IDT && !xeq_mode_r) |=>
      (next_pc_out == ((($past(idt_new) == 32'h0000_0000) ^ $past(opc[0]))
                        ? $past(target) : $past(pc_r) + 32'h0000_0001)))
    else $error("modify-and-test next address wrong");

  a_idt_wb_value: assert property (@(posedge clk_in) disable iff (rst_in)
    (exec && op == BCU_OP_IDT) |=> wb_valid_out ##0
      (wb_value_out == ($past(opc[1]) ? $past(operand_r) - 32'h0000_0001
                                      : $past(operand_r) + 32'h0000_0001)))
    else $error("written back value wrong");

  a_xeq_suppress: assert property (@(posedge clk_in) disable iff (rst_in)
    (exec && xeq_mode_r && cond) |=> (!branch_taken_out && indicator_out[0]))
    else $error("executed branch not suppressed");

endmodule : bcu_branch_condition_unit

// [verification/bcu_far_model.sv]
`timescale 1ns/100ps
module bcu_far_model (
  input  wire logic       clk_in,
  output logic      [3:0] exc_set_out,
  output logic            xeq_cond_met_out,
  output logic            xeq_monitor_out
);
  initial begin
    exc_set_out      = 4'h0;
    xeq_cond_met_out = 1'b0;
    xeq_monitor_out  = 1'b0;
  end
  // One-cycle event pulses, launched just after a rising edge
  task automatic raise(input logic [3:0] exc, input logic cm, input logic mon);
    @(posedge clk_in);
    exc_set_out      <= exc;
    xeq_cond_met_out <= cm;
    xeq_monitor_out  <= mon;
    @(posedge clk_in);
    exc_set_out      <= 4'h0;
    xeq_cond_met_out <= 1'b0;
    xeq_monitor_out  <= 1'b0;
  endtask : raise
endmodule : bcu_far_model

// [verification/testbench.sv]
`timescale 1ns/100ps
`include "bcu_params.svh"
module testbench;
  import bcu_pkg::*;
  logic        clk_in, rst_in, rd, wr, wait_o, taken_o, done_o, wbv_o, sup_o, xc, xm, take;
  logic [5:0]  adr;
  logic [31:0] wdat, rdat_o, npc_o, wbval_o, rdat, pc_v, base_v, idx_v, ind_v, opd, nv;
  logic [3:0]  xs, wbi_o, exc_o, ind_o, r, sel;
  logic [2:0]  rc_o, rc_last;
  logic [7:0]  op;
  bcu_wb_t     wbt_o;
  int          n_fail, checked;

  bcu_branch_condition_unit dut (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdat_o), .avs_waitrequest_out(wait_o), .exc_set_in(xs),
    .xeq_cond_met_in(xc), .xeq_monitor_in(xm), .next_pc_out(npc_o),
    .branch_taken_out(taken_o), .exec_done_out(done_o), .wb_valid_out(wbv_o),
    .wb_target_out(wbt_o), .wb_index_out(wbi_o), .wb_value_out(wbval_o),
    .result_code_out(rc_o), .exc_flags_out(exc_o), .indicator_out(ind_o),
    .monitor_suppress_out(sup_o));
  bcu_far_model far (.clk_in(clk_in), .exc_set_out(xs), .xeq_cond_met_out(xc),
    .xeq_monitor_out(xm));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_in);
    adr  <= a;
    wr   <= w;
    rd   <= !w;
    wdat <= d;
    do begin
      @(posedge clk_in);
      k++;
    end while (wait_o !== 1'b0 && k < 50);
    rdat = rdat_o;
    if (k >= 50) chk(32'h1, 32'h0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic setops(input logic [31:0] pc, o, idx, base, ind);
    pc_v   = pc;
    idx_v  = idx;
    base_v = base;
    ind_v  = ind;
    bus(1'b1, `BCU_OFF_PC, pc);
    bus(1'b1, `BCU_OFF_OPERAND, o);
    bus(1'b1, `BCU_OFF_INDEX, idx);
    bus(1'b1, `BCU_OFF_BASE, base);
    bus(1'b1, `BCU_OFF_INDIRECT, ind);
  endtask : setops

  task automatic exec(input logic [7:0] o, input logic [3:0] rr, t, m,
                      input logic [11:0] n, input logic tk);
    logic [31:0] tgt;
    int          k;
    tgt = (m == 4'h0) ? pc_v + {{20{n[11]}}, n} : base_v + {20'h0, n};
    if (t[2:0] != 3'h0) tgt = tgt + idx_v;
    if (t[3]) tgt = ind_v;
    tgt = tk ? tgt : pc_v + 32'h1;
    bus(1'b1, `BCU_OFF_INSTR, {o, rr, t, m, n});
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (done_o !== 1'b1 && k < 20);
    if (k >= 20) chk(32'h1, 32'h0);
    chk({31'h0, wbv_o}, {31'h0, (o[7:3] == `BCU_OPC_IDT_HI)});
    chk(npc_o, tgt);
    chk({31'h0, taken_o}, {31'h0, tk});
    pc_v = tgt;
  endtask : exec

  task automatic ev(input logic [3:0] e, input logic c, input logic m);
    far.raise(e, c, m);
    @(posedge clk_in);
  endtask : ev

  task automatic end_sim;
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    #100us;
    n_fail++;
    end_sim();
  end

  initial begin
    rst_in = 1'b1;
    adr = 6'h00; rd = 1'b0; wr = 1'b0; wdat = 32'h0; n_fail = 0; checked = 0;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    chk({31'h0, wait_o}, 32'h1);
    bus(1'b0, `BCU_OFF_STATUS, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b0, 6'h3c, 32'h0);
    chk(rdat, 32'h0);
    for (int i = 0; i < 16; i++) begin
      op  = {5'h11, i[2:0]};
      r   = i[2] ? (i[3] ? 4'h9 : 4'h3) : 4'h5;
      opd = i[3] ? 32'h8000_0000 : (i[1] ? 32'h1 : 32'hffff_ffff);
      nv  = i[1] ? opd - 32'h1 : opd + 32'h1;
      take = (nv == 32'h0) ^ i[0];
      rc_last = (nv == 32'h0) ? `BCU_RC_ZERO : (nv[31] ? `BCU_RC_NEG : `BCU_RC_POS);
      setops(32'h100 + i, opd, 32'h20, 32'h400, 32'h7777);
      exec(op, r, i[3] ? 4'h9 : 4'h1, i[0] ? 4'h2 : 4'h0, 12'hff0, take);
      chk(wbval_o, nv);
      chk({29'h0, rc_o}, {29'h0, rc_last});
      chk({28'h0, wbi_o}, {28'h0, r});
      chk({30'h0, wbt_o}, !i[2] ? 32'h1 : (r < 4'h8 ? 32'h2 : 32'h3));
    end
    bus(1'b0, `BCU_OFF_RESULT, 32'h0);
    chk(rdat, nv);
    setops(32'h500, 32'h0, 32'h8, 32'h900, 32'h3210);
    ev(4'ha, 1'b0, 1'b0);
    ev(4'h1, 1'b0, 1'b0);
    chk({28'h0, exc_o}, 32'hb);
    exec(8'h00, 4'hf, 4'h0, 4'h0, 12'h100, 1'b0);
    exec(8'h9d, 4'h4, 4'h0, 4'h0, 12'hff0, 1'b0);
    chk({28'h0, exc_o}, 32'hb);
    exec(8'h9d, 4'h3, 4'h3, 4'h0, 12'h7ff, 1'b1);
    chk({28'h0, exc_o}, 32'h8);
    exec(8'h9d, 4'hf, 4'h8, 4'h1, 12'h010, 1'b1);
    bus(1'b0, `BCU_OFF_EA, 32'h0);
    chk(rdat, 32'h910);
    bus(1'b0, `BCU_OFF_NEXT_PC, 32'h0);
    chk(rdat, 32'h3210);
    chk({28'h0, exc_o}, 32'h0);
    for (int b = 0; b < 4; b++) begin
      sel = 4'h1 << b;
      ev(sel, 1'b0, 1'b0);
      exec(8'h9d, {sel[2:0], sel[3]}, 4'h0, 4'h0, 12'h004, 1'b0);
      exec(8'h9d, sel, 4'h0, 4'h0, 12'h004, 1'b1);
      chk({28'h0, exc_o}, 32'h0);
    end
    chk({29'h0, rc_o}, {29'h0, rc_last});
    ev(4'h0, 1'b1, 1'b0);
    chk({28'h0, ind_o}, 32'h1);
    far.raise(4'h0, 1'b0, 1'b1);
    @(posedge clk_in);
    chk({31'h0, sup_o}, 32'h1);
    chk({28'h0, ind_o}, 32'h3);
    exec(8'h9c, 4'hc, 4'h0, 4'h0, 12'h040, 1'b0);
    exec(8'h9c, 4'h2, 4'h0, 4'h0, 12'h040, 1'b1);
    chk({28'h0, ind_o}, 32'h1);
    exec(8'h9c, 4'h3, 4'h0, 4'h0, 12'h040, 1'b1);
    chk({28'h0, ind_o}, 32'h0);
    chk({29'h0, rc_o}, {29'h0, rc_last});
    setops(32'h600, 32'hffff_ffff, 32'h0, 32'h0, 32'h0);
    bus(1'b1, `BCU_OFF_CTRL, 32'h1);
    exec(8'h88, 4'h5, 4'h0, 4'h0, 12'h010, 1'b0);
    chk({28'h0, ind_o}, 32'h1);
    chk(wbval_o, 32'h0);
    bus(1'b1, `BCU_OFF_CTRL, 32'h0);
    exec(8'h9c, 4'h1, 4'h0, 4'h0, 12'h010, 1'b1);
    chk({28'h0, ind_o}, 32'h0);
    end_sim();
  end
endmodule : testbench
